/* File: wdt_pkg.sv */
// package of constants and types for the watchdog timeout and reset block
package wdt_pkg;

  // ****************************************************************
  // counter and timing
  // ****************************************************************
  localparam int unsigned CNT_W        = 25;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned RST_WIN_CYC  = 512;
  localparam int unsigned EXP_SEL0     = 15;
  localparam int unsigned EXP_SEL1     = 18;
  localparam int unsigned EXP_SEL2     = 21;
  localparam int unsigned EXP_SEL3     = 24;
  localparam int unsigned CLK_MHZ      = 125;

  typedef logic [CNT_W-1:0] wdt_cnt_t;
  typedef logic [SEL_W-1:0] wdt_sel_t;

  localparam wdt_sel_t SEL_2P15 = 2'h0;
  localparam wdt_sel_t SEL_2P18 = 2'h1;
  localparam wdt_sel_t SEL_2P21 = 2'h2;
  localparam wdt_sel_t SEL_2P24 = 2'h3;

  localparam wdt_cnt_t CNT_ZERO = 25'h000_0000;
  localparam wdt_cnt_t CNT_ONE  = 25'h000_0001;
  localparam wdt_cnt_t WIN_CNT  = wdt_cnt_t'(RST_WIN_CYC);

  // ****************************************************************
  // watchdog phase
  // ****************************************************************
  typedef enum logic [1:0] {
    WDT_RUN  = 2'b00,
    WDT_WIN  = 2'b01,
    WDT_RST  = 2'b10
  } wdt_state_e;

endpackage : wdt_pkg

/* File: wdt_evt_if.sv */
// interface carrying timeout events from the compare unit to the control
interface wdt_evt_if;
  import wdt_pkg::*;

  wdt_cnt_t count;
  wdt_cnt_t limit;
  logic     hit_tmo;
  logic     hit_rst;

  modport cmp (
    input  count,
    output limit,
    output hit_tmo,
    output hit_rst
  );
  modport ctl (
    output count,
    input  limit,
    input  hit_tmo,
    input  hit_rst
  );
endinterface : wdt_evt_if

/* File: wdt_cmp.sv */
// decodes the timeout selection into event points on the shared counter
module wdt_cmp (
  // selection
  input  wire wdt_pkg::wdt_sel_t timeout_select,
  // events
  wdt_evt_if.cmp                 evt
);
  import wdt_pkg::*;

  wdt_cnt_t tmo_pt;

  // ****************************************************************
  // timeout point per selection
  // ****************************************************************
  always_comb begin
    unique case (timeout_select)
      SEL_2P15: tmo_pt = CNT_ONE << EXP_SEL0;
      SEL_2P18: tmo_pt = CNT_ONE << EXP_SEL1;
      SEL_2P21: tmo_pt = CNT_ONE << EXP_SEL2;
      SEL_2P24: tmo_pt = CNT_ONE << EXP_SEL3;
    endcase
  end

  // both events compare the one counter, reset point 512 beyond timeout
  assign evt.limit   = tmo_pt;
  assign evt.hit_tmo = (evt.count == tmo_pt - CNT_ONE);
  assign evt.hit_rst = (evt.count == tmo_pt + WIN_CNT - CNT_ONE);

endmodule : wdt_cmp

/* File: wdt_top.sv */
// watchdog timer: shared counter, timeout interrupt and delayed reset
// Function
// - free-running counter on system clock; software restart clears it to zero
// - two-bit select gives timeout of 2^15, 2^18, 2^21 or 2^24 clocks
// - timeout without restart raises interrupt only when enable is set
// - reset point lies exactly 512 clocks after the timeout point
// - no restart by end of the 512-clock window asserts system reset
// - timeout and reset events both come from the one counter
module wdt_top (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // software control
  input  wire logic              wdt_en,
  input  wire logic              restart,
  input  wire logic              int_en,
  input  wire wdt_pkg::wdt_sel_t timeout_select,
  // events
  output logic                   wdt_irq,
  output logic                   sys_rst_req,
  output logic                   in_window
);
  import wdt_pkg::*;

  // every check below shares this clock and reset
  default clocking chk_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  wdt_evt_if evt ();

  wdt_cnt_t   cnt_q;
  wdt_cnt_t   cnt_d;
  wdt_state_e st_q;
  wdt_state_e st_d;
  wdt_cnt_t   win_cyc_q;

  wdt_cmp u_cmp (
    .timeout_select (timeout_select),
    .evt            (evt.cmp)
  );

  assign evt.count = cnt_q;

  // ****************************************************************
  // counter
  // ****************************************************************
  always_comb begin
    cnt_d = cnt_q + CNT_ONE;
    if (restart || !wdt_en || st_q == WDT_RST) begin
      cnt_d = CNT_ZERO;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // ****************************************************************
  // phase
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      WDT_RUN: begin
        if (wdt_en && !restart && evt.hit_tmo) begin
          st_d = WDT_WIN;
        end
      end
      WDT_WIN: begin
        if (restart || !wdt_en) begin
          st_d = WDT_RUN;
        end else if (evt.hit_rst) begin
          st_d = WDT_RST;
        end
      end
      WDT_RST: begin
        st_d = WDT_RUN;
      end
      default: begin
        st_d = WDT_RUN;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= WDT_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs, all registered
  // ****************************************************************
  // irq stands through the window; software answers by restarting
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wdt_irq <= 1'b0;
    end else begin
      wdt_irq <= int_en && (st_d == WDT_WIN);
    end
  end

  // reset is a one-cycle pulse; the chip reset logic stretches it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sys_rst_req <= 1'b0;
    end else begin
      sys_rst_req <= (st_d == WDT_RST);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      in_window <= 1'b0;
    end else begin
      in_window <= (st_d == WDT_WIN);
    end
  end

  // ****************************************************************
  // window tally for the checks
  // ****************************************************************
  // counts window cycles on its own, so the reset point is judged
  // against something other than the compare that makes it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      win_cyc_q <= CNT_ZERO;
    end else if (st_q == WDT_WIN) begin
      win_cyc_q <= win_cyc_q + CNT_ONE;
    end else begin
      win_cyc_q <= CNT_ZERO;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_win_entry;
    st_q == WDT_RUN ##1 st_q == WDT_WIN;
  endsequence

  sequence s_win_exit_rst;
    st_q == WDT_WIN && st_d == WDT_RST;
  endsequence

  sequence s_cancel;
    st_q == WDT_WIN && restart;
  endsequence

  AST_IRQ_NEEDS_EN: assert property (wdt_irq |-> $past(int_en))
    else $error("irq raised while interrupt enable was low");

  AST_IRQ_AT_TMO: assert property (
    (st_q == WDT_RUN && st_d == WDT_WIN && int_en) |=> wdt_irq)
    else $error("irq missing at timeout");

  AST_TMO_AT_LIMIT: assert property (
    (st_q == WDT_RUN && st_d == WDT_WIN) |-> cnt_q == evt.limit - CNT_ONE)
    else $error("timeout not at selected period");

  AST_WIN_LEN: assert property (
    (s_win_entry ##0 (wdt_en && !restart) [*8]) |-> cnt_q > evt.limit)
    else $error("window counter did not continue");

  AST_RST_POINT: assert property (
    s_win_exit_rst |-> cnt_q == evt.limit + WIN_CNT - CNT_ONE)
    else $error("reset not 512 cycles after timeout");

  AST_RST_PULSE: assert property (
    s_win_exit_rst |=> sys_rst_req ##1 !sys_rst_req)
    else $error("reset pulse wrong");

  AST_RESTART_ZERO: assert property (restart |=> cnt_q == CNT_ZERO)
    else $error("restart did not clear counter");

  AST_CANCEL: assert property (
    s_cancel |=> (st_q == WDT_RUN && !sys_rst_req))
    else $error("restart in window did not cancel reset");

  AST_ONE_CNT: assert property (
    sys_rst_req |-> $past(st_q) == WDT_WIN)
    else $error("reset not reached through the timeout window");

  // the one counter steps by one each cycle unless cleared
  AST_CNT_STEP: assert property (
    (wdt_en && !restart && st_q != WDT_RST)
      |=> cnt_q == $past(cnt_q) + CNT_ONE)
    else $error("counter did not step by one");

  AST_DISABLE_CLEAR: assert property (
    !wdt_en |=> (cnt_q == CNT_ZERO && !in_window && !wdt_irq))
    else $error("disable did not clear the watchdog");

  AST_IRQ_IN_WIN: assert property (wdt_irq |-> in_window)
    else $error("irq raised outside the window");

  // independent tally, so a wrong compare point cannot hide here
  AST_WIN_CYCLES: assert property (
    s_win_exit_rst |-> win_cyc_q == WIN_CNT - CNT_ONE)
    else $error("window length differs from 512 cycles");

  AST_RST_QUIET: assert property (
    sys_rst_req |-> (!in_window && !wdt_irq))
    else $error("irq or window still set with reset");

  AST_RST_RESTARTS: assert property (
    sys_rst_req |=> (cnt_q == CNT_ZERO && st_q == WDT_RUN))
    else $error("counter did not restart after reset");

  // a restart on the cycle of the timeout hit wins over the hit
  AST_HIT_RESTART: assert property (
    (st_q == WDT_RUN && restart) |=> st_q == WDT_RUN)
    else $error("restart did not hold the run phase");

  AST_CANCEL_QUIET: assert property (
    s_cancel |=> (!wdt_irq && !in_window))
    else $error("restart in window left irq or window set");

endmodule : wdt_top

/* File: wdt_tb.sv */
// self-checking testbench for the watchdog timeout and reset block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import wdt_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  localparam int N = 1 << EXP_SEL0;

  logic     sys_clk;
  logic     rstn;
  logic     wdt_en;
  logic     restart;
  logic     int_en;
  wdt_sel_t timeout_select;
  logic     wdt_irq;
  logic     sys_rst_req;
  logic     in_window;
  int       errors;
  int       total_checks;

  wdt_top i_dut (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .wdt_en         (wdt_en),
    .restart        (restart),
    .int_en         (int_en),
    .timeout_select (timeout_select),
    .wdt_irq        (wdt_irq),
    .sys_rst_req    (sys_rst_req),
    .in_window      (in_window)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string what, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask : chk

  // settle 1 ns past the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  // counter is zero after the edge that samples restart high
  task automatic kick;
    @(posedge sys_clk);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    #1;
  endtask : kick

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_timeout_irq;
    @(posedge sys_clk);
    int_en         <= 1'b1;
    timeout_select <= SEL_2P15;
    wdt_en         <= 1'b0;
    // one disabled cycle clears the counter, as a restart would
    @(posedge sys_clk);
    wdt_en         <= 1'b1;
    #1;
    tick(N - 1);
    chk("wdt_irq early", 1'b0, wdt_irq);
    tick(1);
    chk("wdt_irq", 1'b1, wdt_irq);
    chk("in_window", 1'b1, in_window);
    tick(511);
    chk("wdt_irq stands", 1'b1, wdt_irq);
    chk("sys_rst_req early", 1'b0, sys_rst_req);
    tick(1);
    chk("sys_rst_req", 1'b1, sys_rst_req);
    chk("in_window after reset", 1'b0, in_window);
    chk("wdt_irq after reset", 1'b0, wdt_irq);
    tick(1);
    chk("sys_rst_req width", 1'b0, sys_rst_req);
    $display("test timeout_irq done");
  endtask : test_timeout_irq

  task automatic test_cancel;
    logic seen;
    @(posedge sys_clk);
    int_en <= 1'b0;
    kick;
    tick(N);
    chk("in_window masked", 1'b1, in_window);
    chk("wdt_irq masked", 1'b0, wdt_irq);
    kick;
    chk("in_window cleared", 1'b0, in_window);
    // the pulse lasts one cycle, so watch every cycle past the old point
    seen = 1'b0;
    repeat (600) begin
      tick(1);
      seen = seen | sys_rst_req;
    end
    chk("sys_rst_req cancelled", 1'b0, seen);
    $display("test cancel done");
  endtask : test_cancel

  // a longer selection must not time out at the shortest period
  task automatic test_select;
    @(posedge sys_clk);
    int_en         <= 1'b1;
    timeout_select <= SEL_2P18;
    kick;
    tick(N + 8);
    chk("in_window long select", 1'b0, in_window);
    chk("wdt_irq long select", 1'b0, wdt_irq);
    $display("test select done");
  endtask : test_select

  // ****************************************************************
  // clock, run and watchdog
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial begin
    #(8ns * 105000);
    errors++;
    $display("unexpected run length: expected end seen timeout");
    wrap_up;
  end

  initial begin
    errors         = 0;
    total_checks   = 0;
    rstn           = 1'b0;
    wdt_en         = 1'b0;
    restart        = 1'b0;
    int_en         = 1'b0;
    timeout_select = SEL_2P15;
    repeat (20) @(posedge sys_clk);
    rstn   <= 1'b1;
    wdt_en <= 1'b1;
    tick(1);
    chk("sys_rst_req after reset", 1'b0, sys_rst_req);
    test_timeout_irq;
    test_cancel;
    test_select;
    wrap_up;
  end

endmodule : tb
